// [mfih_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mfih_params.svh"

// Functional notes
// - Trim up without down, or reverse, conflicts
// - Trim up adds, trim down subtracts frequency
// - Released trim restores prior speed command
// - Trims ignored when operator panel commands
// - Hold qualified time, then sample analog
// - Early release leaves speed command unchanged
// - Sample hold with ramp/motor-pot/trim conflicts
// - Power-up clears sampled reference to zero
// - Outside fault codes report terminal number
// - Even code make contact, odd break
// - Bit one set detects only while running
// - Code group picks stop action or minor
// - Integral reset forces integral to zero
// - Integral hold freezes integral while closed
// - Trim up selected by its own code
module mfih_top
  import mfih_pkg::*;
#(
  parameter int N_TERM = 8,
  parameter int SPD_W = 16,
  parameter int MS_CYCLES = `MFIH_MS_NS / `MFIH_CLK_NS
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Input terminals and drive state
  input wire logic [N_TERM-1:0] term_pin,
  input wire logic drive_running,
  input wire logic [SPD_W-1:0] analog_ref_input_one,
  input wire logic [SPD_W-1:0] analog_ref_input_two,
  // Results
  output logic [SPD_W-1:0] speed_cmd,
  output logic config_conflict_error,
  output mfih_fault_s outside_fault_indication,
  output logic pi_integ_reset,
  output logic pi_integ_hold
);

  localparam int MS_W = $clog2(MS_CYCLES + 1);
  localparam int Q_W = $clog2(`MFIH_QUAL_MS + 1);
  localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);
  localparam logic [Q_W-1:0] Q_LAST = Q_W'(`MFIH_QUAL_MS - 1);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [1:0] ctrl_q; // Source select and analog select
  logic [SPD_W-1:0] trim_frequency_setting; // Trim step
  logic [SPD_W-1:0] speed_base_q; // Command before any trim
  logic [SPD_W-1:0] speed_cmd_q; // Command driven out
  logic [7:0] terminal_function_select [N_TERM]; // Per pin code
  logic conflict_q; // Setting conflict
  mfih_fault_s fault_q; // Outside fault report
  logic irst_q; // Integral reset request
  logic ihld_q; // Integral hold request
  logic [MS_W-1:0] ms_cnt_q; // Millisecond prescaler
  logic [Q_W-1:0] sh_cnt_q; // Elapsed hold time in ms
  logic sh_done_q; // Sample taken for this closure

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire [2:0] fidx = paddr[4:2];
  wire is_func = (paddr[7:5] == `MFIH_FUNC_PAGE) && (int'(fidx) < N_TERM);
  wire hit_ctrl = (paddr == `MFIH_OFF_CTRL);
  wire hit_trim = (paddr == `MFIH_OFF_TRIM);
  wire hit_base = (paddr == `MFIH_OFF_BASE);
  wire hit_stat = (paddr == `MFIH_OFF_STAT);
  wire hit_spd = (paddr == `MFIH_OFF_SPEED);
  wire mapped = hit_ctrl || hit_trim || hit_base || hit_stat ||
                hit_spd || is_func;
  // Fault reset is a write-one pulse, never stored
  wire fault_clr = wr && hit_ctrl && pwdata[`MFIH_CTRL_FRST];
  wire src_term = ctrl_q[`MFIH_CTRL_SRC];

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // ----------------------------------------------------------------
  // Terminal front ends
  // ----------------------------------------------------------------
  logic [N_TERM-1:0] closed; // Synchronised contact levels
  logic [N_TERM-1:0] ext_hit; // Outside fault present
  logic [N_TERM-1:0] ext_major; // Fault group is major
  logic [N_TERM-1:0] f_up, f_dn, f_sh, f_ramp, f_mop, f_irst, f_ihld;
  genvar g;
  generate
    for (g = 0; g < N_TERM; g++) begin : g_term
      mfih_term u_term (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(term_pin[g]),
        .func_code(terminal_function_select[g]),
        .drive_running(drive_running),
        .closed(closed[g]),
        .ext_hit(ext_hit[g]),
        .ext_major(ext_major[g])
      );
      // Which function each pin carries
      assign f_up[g] = terminal_function_select[g] == `MFIH_FN_TRIM_UP;
      assign f_dn[g] = terminal_function_select[g] == `MFIH_FN_TRIM_DN;
      assign f_sh[g] = terminal_function_select[g] == `MFIH_FN_SHOLD;
      assign f_ramp[g] = terminal_function_select[g] == `MFIH_FN_RAMP;
      assign f_mop[g] = (terminal_function_select[g] == `MFIH_FN_MOP_UP) ||
                        (terminal_function_select[g] == `MFIH_FN_MOP_DN);
      assign f_irst[g] = terminal_function_select[g] == `MFIH_FN_IRST;
      assign f_ihld[g] = terminal_function_select[g] == `MFIH_FN_IHLD;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Setting conflicts
  // ----------------------------------------------------------------
  wire has_up = |f_up;
  wire has_dn = |f_dn;
  wire has_sh = |f_sh;
  wire pair_bad = has_up ^ has_dn;
  wire sh_bad = has_sh && (|f_ramp || |f_mop || has_up || has_dn);
  wire conflict_d = pair_bad || sh_bad;

  // ----------------------------------------------------------------
  // Trim adjust
  // ----------------------------------------------------------------
  // A conflicting setting or panel source disables both trims
  wire trim_ok = src_term && !conflict_q;
  wire trim_up = trim_ok && |(closed & f_up) && !(|(closed & f_dn));
  wire trim_dn = trim_ok && |(closed & f_dn) && !(|(closed & f_up));
  wire [SPD_W:0] up_sum = {1'b0, speed_base_q} +
                          {1'b0, trim_frequency_setting};
  wire [SPD_W:0] dn_dif = {1'b0, speed_base_q} -
                          {1'b0, trim_frequency_setting};
  // Saturate rather than wrap, a wrapped speed would be a jump
  wire [SPD_W-1:0] up_val = up_sum[SPD_W] ? {SPD_W{1'b1}} :
                            up_sum[SPD_W-1:0];
  wire [SPD_W-1:0] dn_val = dn_dif[SPD_W] ? '0 : dn_dif[SPD_W-1:0];
  // Base is never touched by trim, so release restores it
  wire [SPD_W-1:0] speed_cmd_d = trim_up ? up_val :
                                 trim_dn ? dn_val :
                                 speed_base_q;

  // ----------------------------------------------------------------
  // Sample and hold qualification
  // ----------------------------------------------------------------
  wire sh_active = |(closed & f_sh) && !conflict_q;
  // Prescaler restarts with the input so 100 ticks are 100 ms exactly
  wire ms_tick = sh_active && (ms_cnt_q == MS_LAST);
  wire sample_now = ms_tick && (sh_cnt_q == Q_LAST) && !sh_done_q;
  wire [SPD_W-1:0] ana_sel = ctrl_q[`MFIH_CTRL_ASEL] ?
                             analog_ref_input_two : analog_ref_input_one;
  // Millisecond timebase, held at zero while the hold input is open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_q <= '0;
    end else if (!sh_active || ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 1'b1;
    end
  end
  // Elapsed hold time; an early release drops the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_cnt_q <= '0;
      sh_done_q <= 1'b0;
    end else if (!sh_active) begin
      sh_cnt_q <= '0;
      sh_done_q <= 1'b0;
    end else if (sample_now) begin
      sh_done_q <= 1'b1; // One sample per closure
    end else if (ms_tick && !sh_done_q) begin
      sh_cnt_q <= sh_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Speed command
  // ----------------------------------------------------------------
  // Reset is power-up, so any earlier sample is gone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_base_q <= '0;
    end else if (sample_now) begin
      speed_base_q <= ana_sel;
    end else if (wr && hit_base) begin
      speed_base_q <= pwdata[SPD_W-1:0];
    end
  end
  // Registered output command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_cmd_q <= '0;
    end else begin
      speed_cmd_q <= speed_cmd_d;
    end
  end

  // ----------------------------------------------------------------
  // Outside faults
  // ----------------------------------------------------------------
  wire [N_TERM-1:0] maj_hit = ext_hit & ext_major;
  wire [N_TERM-1:0] min_hit = ext_hit & ~ext_major;
  logic [3:0] first_term; // Lowest faulted terminal
  mfih_stop_e first_act; // Its stopping action
  // Lowest pin wins; a major hit outranks any minor report
  always_comb begin
    first_term = '0;
    first_act = MFIH_STOP_DECEL;
    for (int i = N_TERM - 1; i >= 0; i--) begin
      if (maj_hit[i] || (!(|maj_hit) && min_hit[i])) begin
        first_term = 4'(i);
        first_act = mfih_stop_e'(terminal_function_select[i][3:2]);
      end
    end
  end
  // Major latches until fault reset; a new hit beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= '0;
    end else begin
      fault_q.minor <= |min_hit;
      if (|maj_hit && !fault_q.major) begin
        fault_q.major <= 1'b1;
        fault_q.action <= first_act;
        fault_q.term <= first_term;
      end else if (fault_clr && !(|maj_hit)) begin
        fault_q.major <= 1'b0;
      end else if (!fault_q.major && |min_hit) begin
        // A minor report names its pin while no major is held
        fault_q.action <= first_act;
        fault_q.term <= first_term;
      end
    end
  end

  // ----------------------------------------------------------------
  // Integral control and conflict flag
  // ----------------------------------------------------------------
  // Reset dominates hold, zero is the stronger request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irst_q <= 1'b0;
      ihld_q <= 1'b0;
      conflict_q <= 1'b0;
    end else begin
      irst_q <= |(closed & f_irst);
      ihld_q <= |(closed & f_ihld) && !(|(closed & f_irst));
      conflict_q <= conflict_d;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `MFIH_CTRL_RST;
      trim_frequency_setting <= '0;
      for (int i = 0; i < N_TERM; i++) begin
        terminal_function_select[i] <= '0;
      end
    end else if (wr) begin
      if (hit_ctrl) begin
        ctrl_q <= pwdata[1:0];
      end
      if (hit_trim) begin
        trim_frequency_setting <= pwdata[SPD_W-1:0];
      end
      if (is_func) begin
        terminal_function_select[fidx] <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [31:0] stat_w; // Status word
  always_comb begin
    stat_w = '0;
    stat_w[`MFIH_ST_CONF] = conflict_q;
    stat_w[`MFIH_ST_MAJOR] = fault_q.major;
    stat_w[`MFIH_ST_ACT_HI:`MFIH_ST_ACT_LO] = fault_q.action;
    stat_w[`MFIH_ST_MINOR] = fault_q.minor;
    stat_w[`MFIH_ST_HOLD] = sh_done_q;
    stat_w[`MFIH_ST_TERM_HI:`MFIH_ST_TERM_LO] = fault_q.term;
  end
  // Read data is combinational within the single access cycle
  assign prdata = !(acc && !pwrite) ? '0 :
                  hit_ctrl ? {30'h0, ctrl_q} :
                  hit_trim ? 32'(trim_frequency_setting) :
                  hit_base ? 32'(speed_base_q) :
                  hit_stat ? stat_w :
                  hit_spd ? 32'(speed_cmd_q) :
                  is_func ? {24'h0, terminal_function_select[fidx]} :
                  '0;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign speed_cmd = speed_cmd_q;
  assign config_conflict_error = conflict_q;
  assign outside_fault_indication = fault_q;
  assign pi_integ_reset = irst_q;
  assign pi_integ_hold = ihld_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence sh_last_tick;
    sh_active && ms_tick && (sh_cnt_q == Q_LAST) && !sh_done_q;
  endsequence
  sequence sh_loaded;
    speed_base_q == $past(ana_sel);
  endsequence
  pair_conflict_a: assert property (@(posedge pclk) disable iff (!presetn)
    (has_up != has_dn) |=> config_conflict_error)
    else $error("trim pair mismatch not flagged");
  trim_add_a: assert property (@(posedge pclk) disable iff (!presetn)
    trim_up |=> speed_cmd == $past(up_val))
    else $error("trim up not added");
  trim_restore_a: assert property (@(posedge pclk) disable iff (!presetn)
    !trim_up && !trim_dn |=> speed_cmd == $past(speed_base_q))
    else $error("speed not restored after trim");
  panel_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    !src_term |-> !trim_up && !trim_dn)
    else $error("trim active under panel source");
  sample_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    sh_last_tick |=> sh_loaded)
    else $error("qualified hold did not load sample");
  early_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    sample_now |-> sh_active && (ms_cnt_q == MS_LAST) &&
                   (sh_cnt_q == Q_LAST))
    else $error("sample taken before qualification");
  hold_conflict_a: assert property (@(posedge pclk) disable iff (!presetn)
    has_sh && has_up |=> config_conflict_error)
    else $error("hold with trim not flagged");
  major_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_q.major && !fault_clr |=> fault_q.major)
    else $error("major fault dropped without reset");
  minor_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 fault_q.minor == $past(|min_hit))
    else $error("minor fault not following input");
  integ_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    |(closed & f_irst) |=> pi_integ_reset && !pi_integ_hold)
    else $error("integral reset not forced");

endmodule
`default_nettype wire

// [mfih_params.svh]
`ifndef MFIH_PARAMS_SVH
`define MFIH_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MFIH_OFF_CTRL 8'h00
`define MFIH_OFF_TRIM 8'h04
`define MFIH_OFF_BASE 8'h08
`define MFIH_OFF_STAT 8'h0c
`define MFIH_OFF_SPEED 8'h10
`define MFIH_FUNC_PAGE 3'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MFIH_CTRL_SRC 0
`define MFIH_CTRL_ASEL 1
`define MFIH_CTRL_FRST 8
`define MFIH_ST_CONF 0
`define MFIH_ST_MAJOR 1
`define MFIH_ST_ACT_LO 2
`define MFIH_ST_ACT_HI 3
`define MFIH_ST_MINOR 4
`define MFIH_ST_HOLD 5
`define MFIH_ST_TERM_LO 8
`define MFIH_ST_TERM_HI 11

// ----------------------------------------------------------------
// Terminal function setting codes
// ----------------------------------------------------------------
`define MFIH_FN_RAMP 8'h0a
`define MFIH_FN_MOP_UP 8'h10
`define MFIH_FN_MOP_DN 8'h11
`define MFIH_FN_TRIM_UP 8'h1c
`define MFIH_FN_TRIM_DN 8'h1d
`define MFIH_FN_SHOLD 8'h1e
`define MFIH_FN_EXTF 4'h2
`define MFIH_FN_IRST 8'h30
`define MFIH_FN_IHLD 8'h31
`define MFIH_EXTF_MINOR 2'h3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define MFIH_CTRL_RST 2'h1
`define MFIH_CLK_NS 4
`define MFIH_MS_NS 1000000
`define MFIH_QUAL_MS 100

`endif

// [mfih_pkg.sv]
package mfih_pkg;

  // Stopping action of an outside fault, in code-group order
  typedef enum logic [1:0] {
    MFIH_STOP_DECEL,
    MFIH_STOP_COAST,
    MFIH_STOP_FAST,
    MFIH_RUN_ON
  } mfih_stop_e;

  // Outside fault report carried as one bundle
  typedef struct packed {
    logic major;
    logic minor;
    mfih_stop_e action;
    logic [3:0] term;
  } mfih_fault_s;

endpackage

// [mfih_term.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mfih_params.svh"

module mfih_term
  import mfih_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Terminal pin and its setting
  input wire logic pin_in,
  input wire logic [7:0] func_code,
  input wire logic drive_running,
  // Qualified terminal state
  output logic closed,
  output logic ext_hit,
  output logic ext_major
);

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic meta_q; // First stage, read only by the second
  logic sync_q; // Stable closed level

  // Two stages, the contact is asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign closed = sync_q;

  // ----------------------------------------------------------------
  // Outside fault decode
  // ----------------------------------------------------------------
  wire is_extf = (func_code[7:4] == `MFIH_FN_EXTF);
  // Odd code is a break contact, so an open pin is the fault
  wire fault_lvl = sync_q ^ func_code[0];
  // Second bit set limits detection to running
  wire det_en = !func_code[1] || drive_running;
  assign ext_hit = is_extf && fault_lvl && det_en;
  // Top group keeps running as a minor fault
  assign ext_major = (func_code[3:2] != `MFIH_EXTF_MINOR);

endmodule
`default_nettype wire

// [mfih_contacts.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Outside contacts and analog sources
// ------------------------------------------------------------
module mfih_contacts (
  // Clock
  input wire logic pclk,
  // Requested contact states and analog levels
  input wire logic [7:0] want_closed,
  input wire logic [15:0] level_one,
  input wire logic [15:0] level_two,
  // Terminal side, high means closed
  output logic [7:0] term_pin,
  output logic [15:0] ain_one,
  output logic [15:0] ain_two
);
  // Contacts move one cycle after the request, clean edges only;
  // bounce is left out, so debouncing is not exercised here
  always_ff @(posedge pclk) begin
    term_pin <= want_closed;
    ain_one <= level_one;
    ain_two <= level_two;
  end
endmodule

`default_nettype wire

// [mfih_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mfih_params.svh"

// ------------------------------------------------------------
// Testbench
// ------------------------------------------------------------
module testbench;
  import mfih_pkg::*;
  // Short millisecond so a 100 ms hold is 1000 cycles
  localparam int MSC = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, conf, irst, ihld, running = 1'b0;
  logic [7:0] want = 8'h00;
  logic [7:0] pins, k;
  logic [15:0] a1, a2, speed;
  logic mj, mn;
  logic [1:0] act;
  mfih_fault_s flt;
  int error_cnt = 0;
  int n_tests = 0;

  // Clock, 4 ns period
  always #2 pclk = ~pclk;

  mfih_contacts i_mfih_contacts (.pclk(pclk), .want_closed(want),
    .level_one(16'h1234), .level_two(16'h0abc), .term_pin(pins),
    .ain_one(a1), .ain_two(a2));

  mfih_top #(.MS_CYCLES(MSC)) i_mfih_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_pin(pins), .drive_running(running), .analog_ref_input_one(a1),
    .analog_ref_input_two(a2), .speed_cmd(speed),
    .config_conflict_error(conf), .outside_fault_indication(flt),
    .pi_integ_reset(irst), .pi_integ_hold(ihld));

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; holds everything until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string w);
    apb(1'b0, a, 32'h0);
    chk(rd, e, w);
  endtask

  // Byte address of a terminal's function code
  function automatic logic [7:0] fc(input int i);
    return 8'h20 + 8'(4 * i);
  endfunction

  task automatic complete_run;
    $display("Counts: %0d checks, %0d errors", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 3700 cycles the tests need
  initial begin
    cyc(30000);
    error_cnt++;
    complete_run();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(4);
    presetn <= 1'b1;
    cyc(2);
    rdc(`MFIH_OFF_CTRL, 32'h1, "ctrl reset");
    rdc(`MFIH_OFF_SPEED, 32'h0, "speed reset");
    rdc(8'hfc, 32'h0, "unmapped data");
    chk(err, 32'h1, "unmapped err");
    $display("test reset done");
    // Trim pairing, add, subtract, restore, panel source
    wr(fc(0), `MFIH_FN_TRIM_UP);
    cyc(3);
    chk(conf, 32'h1, "lone trim");
    wr(fc(1), `MFIH_FN_TRIM_DN);
    cyc(3);
    chk(conf, 32'h0, "trim pair");
    wr(`MFIH_OFF_BASE, 32'h100);
    wr(`MFIH_OFF_TRIM, 32'h10);
    want <= 8'h01;
    cyc(6);
    chk(speed, 32'h110, "trim up");
    want <= 8'h02;
    cyc(6);
    chk(speed, 32'h0f0, "trim down");
    want <= 8'h00;
    cyc(6);
    chk(speed, 32'h100, "restore");
    want <= 8'h03;
    cyc(6);
    chk(speed, 32'h100, "both trims");
    wr(`MFIH_OFF_CTRL, 32'h0);
    want <= 8'h01;
    cyc(6);
    chk(speed, 32'h100, "panel");
    want <= 8'h00;
    wr(`MFIH_OFF_CTRL, 32'h1);
    $display("test trim done");
    // Sample hold conflicts, then qualification
    wr(fc(2), `MFIH_FN_SHOLD);
    cyc(3);
    chk(conf, 32'h1, "hold+trim");
    wr(fc(0), 32'h0);
    wr(fc(1), 32'h0);
    wr(fc(3), `MFIH_FN_RAMP);
    cyc(3);
    chk(conf, 32'h1, "hold+ramp");
    wr(fc(3), `MFIH_FN_MOP_UP);
    cyc(3);
    chk(conf, 32'h1, "hold+mop");
    wr(fc(3), 32'h0);
    cyc(3);
    chk(conf, 32'h0, "hold alone");
    want <= 8'h04;
    cyc(90 * MSC);
    want <= 8'h00;
    cyc(6);
    chk(speed, 32'h100, "early release");
    want <= 8'h04;
    cyc(50 * MSC);
    chk(speed, 32'h100, "count restarted");
    cyc(50 * MSC + 10);
    chk(speed, 32'h1234, "sampled one");
    rdc(`MFIH_OFF_BASE, 32'h1234, "base sampled");
    rdc(`MFIH_OFF_STAT, 32'h20, "sample flag");
    want <= 8'h00;
    wr(`MFIH_OFF_CTRL, 32'h3);
    want <= 8'h04;
    cyc(100 * MSC + 10);
    chk(speed, 32'h0abc, "sampled two");
    want <= 8'h00;
    wr(fc(2), 32'h0);
    wr(`MFIH_OFF_CTRL, 32'h1);
    $display("test sample hold done");
    // Every outside fault code on terminal 3
    for (int c = 32; c < 48; c++) begin
      k = 8'(c);
      mn = k[3] & k[2];
      mj = ~mn;
      act = k[3:2];
      running <= 1'b0;
      want <= {4'h0, k[0], 3'h0};
      wr(fc(3), {24'h0, k});
      cyc(6);
      chk({flt.major, flt.minor}, 32'h0, "idle level");
      want <= {4'h0, ~k[0], 3'h0};
      cyc(6);
      chk({flt.major, flt.minor}, k[1] ? 2'b00 : {mj, mn}, "stopped");
      running <= 1'b1;
      cyc(6);
      chk(flt, {mj, mn, act, 4'h3}, "fault");
      rdc(`MFIH_OFF_STAT, {20'h0, 4'h3, 3'h0, mn, act, mj, 1'b0},
          "status");
      want <= {4'h0, k[0], 3'h0};
      cyc(6);
      chk({flt.major, flt.minor}, {mj, 1'b0}, "released");
      wr(fc(3), 32'h0);
      wr(`MFIH_OFF_CTRL, 32'h101);
      cyc(3);
      chk(flt.major, 32'h0, "fault reset");
    end
    $display("test outside fault done");
    // Integral hold, then reset over hold
    wr(fc(4), `MFIH_FN_IHLD);
    wr(fc(5), `MFIH_FN_IRST);
    rdc(fc(4), `MFIH_FN_IHLD, "code readback");
    want <= 8'h10;
    cyc(6);
    chk({irst, ihld}, 32'h1, "integ hold");
    want <= 8'h30;
    cyc(6);
    chk({irst, ihld}, 32'h2, "integ reset");
    want <= 8'h00;
    cyc(6);
    chk({irst, ihld}, 32'h0, "integ open");
    $display("test integral done");
    // Power cycle drops the sampled reference
    presetn <= 1'b0;
    cyc(2);
    chk(speed, 32'h0, "power cycle");
    presetn <= 1'b1;
    cyc(2);
    rdc(`MFIH_OFF_SPEED, 32'h0, "speed after power");
    rdc(`MFIH_OFF_CTRL, 32'h1, "ctrl after power");
    $display("test power cycle done");
    complete_run();
  end
endmodule

`default_nettype wire
